// *** core/host_serial_rate_flow_status.v ***
// Host serial port with programmable rate, CTS/RTS flow control and hop status outputs.
// Assumes a single sys_clk domain at the reference rate, AXI4-Lite master, pins asynchronous.
//
// Function
// - Divisor is reference over sixty-four times rate.
// - Rates below 1200 baud are unsupported.
// - Rate valid within three percent of host.
// - Test pin low at reset forces 9600.
// - Low divisor byte encodes common rates.
// - Each rate has timeout and stop delay.
// - Defaults give 57600 baud after reset.
// - Stop delay zero gives short stop bit.
// - Serial rate independent of radio rate.
// - Status outputs work only when enabled.
// - Hop-bin-zero flag low during bin zero.
// - Flag falls at bin start, rises at end.
// - Ack flag rises within 75 us.
// - Ack flag holds until next hop ends; the code clears it at the second hop_frame rise after the flag rises.
// - Status functions exclusive with modem mode.
// - CTS high when buffer reaches threshold.
// - RTS high withholds output to host.
// - Buffer holds 256 bytes, overflow lost.
// - Start low, data LSB first, stop high.
// - Forced mode 8-N-1 until reset.
//
// The AXI4-Lite register port is this design's own decision.
`include "host_serial_consts.vh"

module host_serial_rate_flow_status #(
   parameter DEPTH_LOG2 = 8,
   parameter ACK_CYCLES = (`ACK_DELAY_US * (`REF_CLK_HZ / 1000000))
) (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst_n,
   // AXI4-Lite write address
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Host serial pins
   input  wire        rx_pin,
   output reg         tx_pin,
   output reg         cts_pin,
   input  wire        rts_pin,
   input  wire        test_n_pin,
   // Radio side events, synchronous to sys_clk
   input  wire        hop_frame,
   input  wire        hop_bin_zero,
   input  wire        rf_ack_valid,
   // Status outputs
   output reg         hop_bin_zero_flag,
   output reg         rf_ack_flag
);

   localparam DEPTH = 1 << DEPTH_LOG2;
   localparam ST_IDLE  = 2'b00;
   localparam ST_START = 2'b01;
   localparam ST_DATA  = 2'b10;
   localparam ST_STOP  = 2'b11;

   // ==========================================================
   // Pin synchronisers
   reg [1:0] rx_sync_reg;
   reg [1:0] rts_sync_reg;
   reg [1:0] test_sync_reg;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_sync_reg   <= 2'h3;
         rts_sync_reg  <= 2'h3;
         test_sync_reg <= 2'h3;
      end else begin
         rx_sync_reg   <= {rx_sync_reg[0], rx_pin};
         rts_sync_reg  <= {rts_sync_reg[0], rts_pin};
         test_sync_reg <= {test_sync_reg[0], test_n_pin};
      end
   end
   wire rx_s   = rx_sync_reg[1];
   wire rts_s  = rts_sync_reg[1];

   // ==========================================================
   // Registers
   reg [7:0] stop_bit_delay_reg;
   reg [7:0] rate_divisor_low_reg;
   reg [7:0] rate_divisor_high_reg;
   reg [7:0] interface_timeout_reg;
   reg [7:0] cts_release_threshold_reg;
   reg [2:0] control_reg;
   reg       forced_rate_reg;
   reg [2:0] strap_cnt_reg;

   // strap capture: sampled a few cycles after release, once the synchroniser settled.
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         strap_cnt_reg   <= 3'h0;
         forced_rate_reg <= 1'b0;
      end else if (strap_cnt_reg != 3'h3) begin
         strap_cnt_reg <= strap_cnt_reg + 3'h1;
         if (strap_cnt_reg == 3'h2)
            forced_rate_reg <= ~test_sync_reg[1];
      end
   end

   // rate byte or forced 9600 value; high byte ignored.
   wire [7:0] active_div = forced_rate_reg ? `FORCED_RATE_DIV : rate_divisor_low_reg;
   wire status_on = control_reg[`CTL_STATUS_EN] & ~control_reg[`CTL_MODEM_MODE] &
                    ~forced_rate_reg;

   // ==========================================================
   // Bit timing: prescale by 256-divisor then count 64 ticks per bit period.
   reg [7:0] rate_cnt_reg;
   reg       tick_reg;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         rate_cnt_reg <= 8'h0;
         tick_reg     <= 1'b0;
      end else begin
         // bit-rate tick: one tick per (256-divisor) reference cycles.
         tick_reg <= (rate_cnt_reg == 8'h0);
         if (rate_cnt_reg == 8'h0)
            rate_cnt_reg <= 8'h0 - active_div - 8'h1;
         else
            rate_cnt_reg <= rate_cnt_reg - 8'h1;
      end
   end
   // ==========================================================
   // Receive buffer (host to device) and transmit buffer (device to host)
   reg [7:0]          rxbuf [0:DEPTH-1];
   reg [DEPTH_LOG2:0] rx_wp_reg;
   reg [DEPTH_LOG2:0] rx_rp_reg;
   reg [7:0]          txbuf [0:DEPTH-1];
   reg [DEPTH_LOG2:0] tx_wp_reg;
   reg [DEPTH_LOG2:0] tx_rp_reg;
   wire [DEPTH_LOG2:0] rx_count = rx_wp_reg - rx_rp_reg;
   wire [DEPTH_LOG2:0] tx_count = tx_wp_reg - tx_rp_reg;
   wire rx_full  = rx_count[DEPTH_LOG2];
   wire rx_empty = (rx_count == 0);
   wire tx_full  = tx_count[DEPTH_LOG2];
   wire tx_empty = (tx_count == 0);

   // ==========================================================
   // Serial receiver
   reg [1:0] rs_state_reg;
   reg [7:0] rs_smp_reg;
   reg [2:0] rs_bit_reg;
   reg [7:0] rs_shift_reg;
   reg       rs_push;
   reg       overrun_reg;
   always @(posedge sys_clk) begin
      rs_push <= 1'b0;
      if (!rst_n) begin
         rs_state_reg <= ST_IDLE;
         rs_smp_reg   <= 8'h0;
         rs_bit_reg   <= 3'h0;
         rs_shift_reg <= 8'h0;
      end else if (tick_reg) begin
         rs_smp_reg <= rs_smp_reg + 8'h1;
         case (rs_state_reg)
            ST_IDLE: begin
               rs_smp_reg <= 8'h0;
               if (!rx_s)
                  rs_state_reg <= ST_START;
            end
            ST_START: begin
               if (rs_smp_reg == `SAMPLE_HALF) begin
                  rs_smp_reg <= 8'h0;
                  rs_bit_reg <= 3'h0;
                  rs_state_reg <= rx_s ? ST_IDLE : ST_DATA;
               end
            end
            ST_DATA: begin
               if (rs_smp_reg == `SAMPLES_PER_BIT - 8'h1) begin
                  rs_smp_reg <= 8'h0;
                  rs_shift_reg <= {rx_s, rs_shift_reg[7:1]};
                  rs_bit_reg <= rs_bit_reg + 3'h1;
                  if (rs_bit_reg == 3'h7)
                     rs_state_reg <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (rs_smp_reg == `SAMPLES_PER_BIT - 8'h1) begin
                  rs_state_reg <= ST_IDLE;
                  rs_push <= rx_s;
               end
            end
            default: rs_state_reg <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Serial transmitter
   reg [1:0] ts_state_reg;
   reg [7:0] ts_smp_reg;
   reg [7:0] ts_stop_reg;
   reg [2:0] ts_bit_reg;
   reg [7:0] ts_shift_reg;
   // RTS gating: with CTL_RTS_EN set, a new character starts only while RTS is low.
   wire ts_start = (ts_state_reg == ST_IDLE) & ~tx_empty &
                   ~(control_reg[`CTL_RTS_EN] & rts_s);
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         ts_state_reg <= ST_IDLE;
         ts_smp_reg   <= 8'h0;
         ts_stop_reg  <= 8'h0;
         ts_bit_reg   <= 3'h0;
         ts_shift_reg <= 8'h0;
         tx_pin       <= 1'b1;
      end else begin
         case (ts_state_reg)
            ST_IDLE: begin
               tx_pin <= 1'b1;
               if (ts_start) begin
                  ts_shift_reg <= txbuf[tx_rp_reg[DEPTH_LOG2-1:0]];
                  ts_smp_reg   <= 8'h0;
                  ts_state_reg <= ST_START;
               end
            end
            ST_START: begin
               tx_pin <= 1'b0;
               if (tick_reg) begin
                  ts_smp_reg <= ts_smp_reg + 8'h1;
                  if (ts_smp_reg == `SAMPLES_PER_BIT - 8'h1) begin
                     ts_smp_reg <= 8'h0;
                     ts_bit_reg <= 3'h0;
                     ts_state_reg <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               tx_pin <= ts_shift_reg[0];
               if (tick_reg) begin
                  ts_smp_reg <= ts_smp_reg + 8'h1;
                  if (ts_smp_reg == `SAMPLES_PER_BIT - 8'h1) begin
                     ts_smp_reg   <= 8'h0;
                     ts_shift_reg <= {1'b0, ts_shift_reg[7:1]};
                     ts_bit_reg   <= ts_bit_reg + 3'h1;
                     if (ts_bit_reg == 3'h7) begin
                        ts_state_reg <= ST_STOP;
                        ts_stop_reg  <= stop_bit_delay_reg;
                     end
                  end
               end
            end
            ST_STOP: begin
               // stop length: prescaled count from the stop-bit delay value.
               tx_pin <= 1'b1;
               if (tick_reg) begin
                  ts_smp_reg <= ts_smp_reg + 8'h1;
                  if (ts_smp_reg == `SAMPLES_PER_BIT - 8'h1) begin
                     ts_smp_reg <= 8'h0;
                     if (ts_stop_reg == 8'h0)
                        ts_state_reg <= ST_IDLE;
                     else
                        ts_stop_reg <= ts_stop_reg - 8'h1;
                  end
               end
            end
            default: ts_state_reg <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // AXI4-Lite slave
   wire [7:0] wr_idx = s_axi_awaddr[9:2];
   wire [7:0] rd_idx = s_axi_araddr[9:2];
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
   wire wr_hit = (wr_idx == `IDX_STOP_BIT_DELAY) | (wr_idx == `IDX_RATE_DIV_LOW) |
                 (wr_idx == `IDX_RATE_DIV_HIGH) | (wr_idx == `IDX_IF_TIMEOUT) |
                 (wr_idx == `IDX_CTS_THRESHOLD) | (wr_idx == `IDX_CONTROL) |
                 (wr_idx == `IDX_TX_DATA);
   wire tx_push = wr_go & s_axi_wstrb[0] & (wr_idx == `IDX_TX_DATA) & ~tx_full;
   wire rx_pop  = rd_go & (rd_idx == `IDX_RX_DATA) & ~rx_empty;

   reg [31:0] rd_val;
   reg        rd_hit;
   always @* begin
      rd_val = 32'h0;
      rd_hit = 1'b1;
      case (rd_idx)
         `IDX_STOP_BIT_DELAY: rd_val[7:0] = stop_bit_delay_reg;
         `IDX_RATE_DIV_LOW:   rd_val[7:0] = rate_divisor_low_reg;
         `IDX_RATE_DIV_HIGH:  rd_val[7:0] = rate_divisor_high_reg;
         `IDX_IF_TIMEOUT:     rd_val[7:0] = interface_timeout_reg;
         `IDX_CTS_THRESHOLD:  rd_val[7:0] = cts_release_threshold_reg;
         `IDX_CONTROL:        rd_val[2:0] = control_reg;
         `IDX_STATUS:         rd_val[7:0] = {2'h0, overrun_reg, forced_rate_reg,
                                             tx_full, tx_empty, rx_full, rx_empty};
         `IDX_RX_DATA:        rd_val[7:0] = rxbuf[rx_rp_reg[DEPTH_LOG2-1:0]];
         default:             rd_hit = 1'b0;
      endcase
   end

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `RESP_OKAY;
         s_axi_rdata   <= 32'h0;
         stop_bit_delay_reg        <= `RST_STOP_BIT_DELAY;
         rate_divisor_low_reg      <= `RST_RATE_DIV_LOW;
         rate_divisor_high_reg     <= 8'h0;
         interface_timeout_reg     <= `RST_IF_TIMEOUT;
         cts_release_threshold_reg <= `RST_CTS_THRESHOLD;
         control_reg               <= 3'h0;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready  <= wr_go;
         s_axi_arready <= rd_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            if (s_axi_wstrb[0]) begin
               case (wr_idx)
                  `IDX_STOP_BIT_DELAY: stop_bit_delay_reg        <= s_axi_wdata[7:0];
                  `IDX_RATE_DIV_LOW:   rate_divisor_low_reg      <= s_axi_wdata[7:0];
                  `IDX_RATE_DIV_HIGH:  rate_divisor_high_reg     <= s_axi_wdata[7:0];
                  `IDX_IF_TIMEOUT:     interface_timeout_reg     <= s_axi_wdata[7:0];
                  `IDX_CTS_THRESHOLD:  cts_release_threshold_reg <= s_axi_wdata[7:0];
                  `IDX_CONTROL:        control_reg               <= s_axi_wdata[2:0];
                  default:             control_reg               <= control_reg;
               endcase
            end
         end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Buffer pointers and CTS
   always @(posedge sys_clk) begin
      if (rs_push & ~rx_full)
         rxbuf[rx_wp_reg[DEPTH_LOG2-1:0]] <= rs_shift_reg;
      if (tx_push)
         txbuf[tx_wp_reg[DEPTH_LOG2-1:0]] <= s_axi_wdata[7:0];
   end
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         rx_wp_reg   <= 0;
         rx_rp_reg   <= 0;
         tx_wp_reg   <= 0;
         tx_rp_reg   <= 0;
         overrun_reg <= 1'b0;
         cts_pin     <= 1'b1;
      end else begin
         // overflow drop: bytes arriving to a full buffer are lost and flagged.
         if (rs_push & ~rx_full)
            rx_wp_reg <= rx_wp_reg + 1'b1;
         if (rs_push & rx_full)
            overrun_reg <= 1'b1;
         else if (rx_pop)
            overrun_reg <= 1'b0;
         if (rx_pop)
            rx_rp_reg <= rx_rp_reg + 1'b1;
         if (tx_push)
            tx_wp_reg <= tx_wp_reg + 1'b1;
         if (ts_start)
            tx_rp_reg <= tx_rp_reg + 1'b1;
         // CTS threshold: high once count reaches the release threshold.
         cts_pin <= (rx_count >= {1'b0, cts_release_threshold_reg}) | rx_full;
      end
   end

   // ==========================================================
   // Hop status and acknowledgement outputs
   reg        hop_prev_reg;
   reg        ack_pending_reg;
   reg        ack_armed_reg;
   reg [11:0] ack_cnt_reg;
   wire hop_fall = hop_prev_reg & ~hop_frame;
   wire hop_rise = ~hop_prev_reg & hop_frame;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         hop_prev_reg      <= 1'b1;
         hop_bin_zero_flag <= 1'b1;
         rf_ack_flag       <= 1'b0;
         ack_pending_reg   <= 1'b0;
         ack_armed_reg     <= 1'b0;
         ack_cnt_reg       <= 12'h0;
      end else begin
         // hop marker from the sequencer, same clock domain.
         hop_prev_reg <= hop_frame;
         if (!status_on)
            hop_bin_zero_flag <= 1'b1;
         else if (hop_fall & hop_bin_zero)
            hop_bin_zero_flag <= 1'b0;
         else if (hop_rise)
            hop_bin_zero_flag <= 1'b1;
         // ack within delay: raised well inside the bound.
         if (!status_on) begin
            rf_ack_flag     <= 1'b0;
            ack_pending_reg <= 1'b0;
            ack_armed_reg   <= 1'b0;
         end else begin
            if (rf_ack_valid) begin
               ack_pending_reg <= 1'b1;
               ack_cnt_reg     <= 12'h0;
            end else if (ack_pending_reg) begin
               ack_cnt_reg <= ack_cnt_reg + 12'h1;
               if (ack_cnt_reg == 12'h1 || ack_cnt_reg == ACK_CYCLES[11:0]) begin
                  rf_ack_flag     <= 1'b1;
                  ack_pending_reg <= 1'b0;
                  ack_armed_reg   <= 1'b0;
               end
            end
            // ack hold: cleared at the second hop_frame rising edge after the flag rises.
            if (rf_ack_flag & hop_rise & ~rf_ack_valid) begin
               if (ack_armed_reg)
                  rf_ack_flag <= 1'b0;
               else
                  ack_armed_reg <= 1'b1;
            end
         end
      end
   end

endmodule

// *** core/host_serial_consts.vh ***
// Constants for the host serial port, flow control and hop status block.
// Assumes inclusion by bare name from the core design file.
`ifndef HOST_SERIAL_CONSTS_VH
`define HOST_SERIAL_CONSTS_VH

// Register indices as printed; byte address is four times the index.
`define IDX_STOP_BIT_DELAY   8'h3F
`define IDX_RATE_DIV_LOW     8'h42
`define IDX_RATE_DIV_HIGH    8'h43
`define IDX_IF_TIMEOUT       8'h58
`define IDX_CTS_THRESHOLD    8'h5D
`define IDX_CONTROL          8'h60
`define IDX_STATUS           8'h61
`define IDX_TX_DATA          8'h62
`define IDX_RX_DATA          8'h63

// Reset values: 57600 baud defaults, plus the forced 9600 divisor.
`define RST_RATE_DIV_LOW     8'hFC
`define RST_STOP_BIT_DELAY   8'h03
`define RST_IF_TIMEOUT       8'h02
`define RST_CTS_THRESHOLD    8'hF0
`define FORCED_RATE_DIV      8'hE8

// Control register fields.
`define CTL_RTS_EN           0
`define CTL_STATUS_EN        1
`define CTL_MODEM_MODE       2

// Bit timing.
`define SAMPLE_HALF          8'd32
`define SAMPLES_PER_BIT      8'd64
`define REF_CLK_HZ           14745600
`define ACK_DELAY_US         75

// AXI responses.
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`endif

// *** testbench/host_serial_rate_flow_status_sva.sv ***
// Port-level checks for the host serial, flow control and hop status block.
// Assumes a bind to the design top.
module host_serial_sva (
   // Clock and reset
   input wire        sys_clk,
   input wire        rst_n,
   // Register bus
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // Radio events and status outputs
   input wire        hop_frame,
   input wire        hop_bin_zero,
   input wire        rf_ack_valid,
   input wire        hop_bin_zero_flag,
   input wire        rf_ack_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Register bus answers
   property p_wr_take; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
      |=> s_axi_awready && s_axi_wready && s_axi_bvalid; endproperty
   a_wr_take: assert property (p_wr_take) else $error("write not taken");
   property p_wr_pulse; s_axi_awready |=> !s_axi_awready; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("awready held");
   property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_done: assert property (p_b_done) else $error("bvalid kept");
   property p_rd_take; s_axi_arvalid && !s_axi_rvalid
      |=> s_axi_arready && s_axi_rvalid; endproperty
   a_rd_take: assert property (p_rd_take) else $error("read not taken");
   property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_r_done: assert property (p_r_done) else $error("rvalid kept");
   // ==========================================================
   // Status outputs
   property p_ack_rise; $rose(rf_ack_flag) |-> $past(rf_ack_valid, 3); endproperty
   a_ack_rise: assert property (p_ack_rise) else $error("ack flag cause");
   property p_ack_fall; $fell(rf_ack_flag) |-> $past(hop_frame) && !$past(hop_frame, 2);
   endproperty
   a_ack_fall: assert property (p_ack_fall) else $error("ack flag drop");
   property p_hop_fall; $fell(hop_bin_zero_flag)
      |-> $past(hop_bin_zero) && !$past(hop_frame) && $past(hop_frame, 2); endproperty
   a_hop_fall: assert property (p_hop_fall) else $error("hop flag fall");
   property p_hop_rise; $rose(hop_bin_zero_flag)
      |-> $past(hop_frame) && !$past(hop_frame, 2); endproperty
   a_hop_rise: assert property (p_hop_rise) else $error("hop flag rise");
endmodule

// *** testbench/host_uart_model.sv ***
// Behavioural host UART facing the device serial pins.
// Assumes the bench sets bit_cyc to the device bit period in sys_clk cycles.
module host_uart_model (
   input  wire  sys_clk,
   input  wire  tx_pin,
   input  wire  cts_pin,
   output logic rx_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // host rate matched to the programmed divisor
   int bit_cyc = 128;
   initial rx_pin = 1'b1;
   // ==========================================================
   // host starts each byte only while CTS is low
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      while (cts_pin !== 1'b0) @(posedge sys_clk);
      for (int k = 0; k < 10; k++) begin
         @(posedge sys_clk);
         rx_pin <= f[k];
         repeat (bit_cyc - 1) @(posedge sys_clk);
      end
   endtask
   // sampling at bit centres, start low and stop high
   task automatic recv(output logic [7:0] b, output logic ok);
      while (tx_pin !== 1'b0) @(posedge sys_clk);
      repeat (bit_cyc / 2) @(posedge sys_clk);
      ok = (tx_pin === 1'b0);
      for (int k = 0; k < 8; k++) begin
         repeat (bit_cyc) @(posedge sys_clk);
         b[k] = tx_pin;
      end
      repeat (bit_cyc) @(posedge sys_clk);
      ok = ok && (tx_pin === 1'b1);
   endtask
endmodule

// *** testbench/host_serial_rate_flow_status_tb.sv ***
// Self-checking bench for the host serial, flow control and hop status block.
// Assumes core/ on the include path.
module host_serial_rate_flow_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, rx_pin, tx_pin, cts_pin, rts_pin, test_n_pin, hop_frame;
   logic        hop_bin_zero, rf_ack_valid, hop_bin_zero_flag, rf_ack_flag, ok, low;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0]  b;
   int          mismatches = 0;
   int          n_tests = 0;
   typedef struct {logic [7:0] idx; logic wr; logic [7:0] wd, rd; logic [1:0] rsp;} row_t;
   // Reset values, then writes; last row unmapped.
   row_t rows [10] = '{'{8'h3F, 1'b0, 8'h00, 8'h03, 2'h0}, '{8'h42, 1'b0, 8'h00, 8'hFC, 2'h0},
      '{8'h58, 1'b0, 8'h00, 8'h02, 2'h0}, '{8'h5D, 1'b0, 8'h00, 8'hF0, 2'h0},
      '{8'h42, 1'b1, 8'hFE, 8'hFE, 2'h0}, '{8'h43, 1'b1, 8'h00, 8'h00, 2'h0},
      '{8'h3F, 1'b1, 8'h00, 8'h00, 2'h0}, '{8'h58, 1'b1, 8'h21, 8'h21, 2'h0},
      '{8'h5D, 1'b1, 8'h02, 8'h02, 2'h0}, '{8'h10, 1'b1, 8'h55, 8'h00, 2'h2}};
   host_serial_rate_flow_status dut (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_pin, .tx_pin, .cts_pin,
      .rts_pin, .test_n_pin, .hop_frame, .hop_bin_zero, .rf_ack_valid, .hop_bin_zero_flag,
      .rf_ack_flag);
   host_uart_model host (.sys_clk, .tx_pin, .cts_pin, .rx_pin);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_awaddr <= {22'h000000, idx, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= {22'h000000, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // One hop: frame falls at bin start and rises at bin end.
   task automatic hop(input logic bz, input logic en);
      @(posedge sys_clk);
      hop_frame <= 1'b0;
      hop_bin_zero <= bz;
      repeat (20) @(posedge sys_clk);
      chk(hop_bin_zero_flag, !(bz && en));
      hop_frame <= 1'b1;
      hop_bin_zero <= 1'b0;
      repeat (20) @(posedge sys_clk);
      chk(hop_bin_zero_flag, 1'b1);
   endtask
   task automatic ack(input logic exp);
      @(posedge sys_clk);
      rf_ack_valid <= 1'b1;
      @(posedge sys_clk);
      rf_ack_valid <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk(rf_ack_flag, exp);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hF;
      {rts_pin, rf_ack_valid, hop_bin_zero, rst_n} = 4'h0;
      {test_n_pin, hop_frame} = 2'h3;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         if (rows[i].wr) begin
            axi_wr(rows[i].idx, rows[i].wd, rsp);
            chk(rsp, rows[i].rsp);
         end
         axi_rd(rows[i].idx, rd, rsp);
         chk(rd, rows[i].rd);
         chk(rsp, rows[i].rsp);
      end
      chk(cts_pin, 1'b0);
      axi_wr(8'h62, 8'hA5, rsp);
      host.recv(b, ok);
      chk(b, 8'hA5);
      chk(ok, 1'b1);
      axi_wr(8'h60, 8'h01, rsp);
      rts_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      axi_wr(8'h62, 8'h3C, rsp);
      low = 1'b0;
      repeat (400) begin
         @(posedge sys_clk);
         if (tx_pin !== 1'b1) low = 1'b1;
      end
      chk(low, 1'b0);
      rts_pin <= 1'b0;
      host.recv(b, ok);
      chk(b, 8'h3C);
      host.send(8'h5A);
      host.send(8'hC3);
      repeat (64) @(posedge sys_clk);
      chk(cts_pin, 1'b1);
      axi_rd(8'h63, rd, rsp);
      chk(rd, 32'h0000005A);
      axi_rd(8'h63, rd, rsp);
      chk(rd, 32'h000000C3);
      repeat (4) @(posedge sys_clk);
      chk(cts_pin, 1'b0);
      axi_wr(8'h60, 8'h02, rsp);
      hop(1'b0, 1'b1);
      hop(1'b1, 1'b1);
      ack(1'b1);
      hop(1'b0, 1'b1);
      chk(rf_ack_flag, 1'b1);
      hop(1'b0, 1'b1);
      chk(rf_ack_flag, 1'b0);
      for (int i = 0; i < 2; i++) begin
         axi_wr(8'h60, i ? 8'h06 : 8'h00, rsp);
         ack(1'b0);
         hop(1'b1, 1'b0);
      end
      rst_n <= 1'b0;
      test_n_pin <= 1'b0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      axi_rd(8'h61, rd, rsp);
      chk(rd[4], 1'b1);
      host.bit_cyc = 1536;
      axi_wr(8'h62, 8'h96, rsp);
      host.recv(b, ok);
      chk(b, 8'h96);
      chk(ok, 1'b1);
      report_and_stop;
   end
   // A hang counts as a mismatch and ends the run the normal way.
   initial begin
      #3000000;
      mismatches++;
      report_and_stop;
   end
endmodule
bind host_serial_rate_flow_status host_serial_sva chk_i (.sys_clk, .rst_n, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .hop_frame, .hop_bin_zero, .rf_ack_valid,
   .hop_bin_zero_flag, .rf_ack_flag);
